// [verilog/cuf_defs.vh]
// register indices, field positions, reset values and timing counts
`ifndef CUF_DEFS_VH
`define CUF_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define CUF_IDX_FLAGS   8'h37
`define CUF_IDX_IRQEN   8'h38
`define CUF_IDX_PDIV    8'h40
`define CUF_ADDR_W      10

// ----------------------------------------------------------------
// bit positions of the flag register
// ----------------------------------------------------------------
`define CUF_B_TICK      7
`define CUF_B_POR       6
`define CUF_B_LVR       5
`define CUF_B_PLLCHG    4
`define CUF_B_PLLOK     3
`define CUF_B_BADADR    2
`define CUF_B_OSCCHG    1
`define CUF_B_OSCOK     0

// ----------------------------------------------------------------
// field widths, masks and reset values
// ----------------------------------------------------------------
`define CUF_IRQEN_MASK  8'h92
`define CUF_IRQEN_RST   8'h00
`define CUF_PDIV_W      5
`define CUF_PDIV_RST    5'h00
`define CUF_DIV_W       6
`define CUF_UNLOCK_DIV  6'h04
`define CUF_POR_FLAG_RST 1'b1
`define CUF_LVR_FLAG_RST 1'b1
`define CUF_BAD_FLAG_RST 1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CUF_CLK_NS      40
`define CUF_QUAL_NS     1000
`define CUF_QUAL_CYC    ((`CUF_QUAL_NS + `CUF_CLK_NS - 1) / `CUF_CLK_NS)

`endif

// [verilog/cuf_w1c_flag.v]
// sticky event flag with write-one-to-clear
module cuf_w1c_flag (
	// clock and reset
	input  wire CLK,
	input  wire RESET_N,
	// event and clear
	input  wire SET,
	input  wire CLR,
	// flag
	output reg  FLAG_Q
);

	// set beats clear so an event in the clearing cycle survives
	always @(posedge CLK) begin
		if (!RESET_N) begin
			FLAG_Q <= 1'b0;
		end else if (SET) begin
			FLAG_Q <= 1'b1;
		end else if (CLR) begin
			FLAG_Q <= 1'b0;
		end
	end

endmodule // cuf_w1c_flag

// [verilog/cuf_osc_qual.v]
// oscillator qualifier: good input must hold for a full window
module cuf_osc_qual #(
	parameter integer QUAL_CYC = 25
) (
	// clock and reset
	input  wire CLK,
	input  wire RESET_N,
	// filter verdict and forced drop
	input  wire GOOD,
	input  wire DROP,
	// result
	output reg  QUAL_Q
);

	localparam integer CW = 16;
	localparam [CW-1:0] LAST = QUAL_CYC[CW-1:0];
	localparam [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};

	reg [CW-1:0] cnt_q;

	// any gap in the verdict restarts the window
	always @(posedge CLK) begin
		if (!RESET_N || DROP || !GOOD) begin
			cnt_q  <= {CW{1'b0}};
			QUAL_Q <= 1'b0;
		end else if (cnt_q >= LAST - ONE) begin
			QUAL_Q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + ONE;
		end
	end

endmodule // cuf_osc_qual

// [verilog/cuf_flag_regs.v]
// clock unit flag and interrupt enable registers behind APB
//
// How it works
// RL1: tick timeout sets flag bit 7
// RL2: flags clear only by writing one
// RL3: tick flag with enable raises request
// RL4: only power-on reset sets bit 6
// RL5: low-voltage or power-on sets bit 5
// RL6: bad address sets bit 2; power-on clears
// RL7: lock status change sets bit 4
// RL8: lock change flag with enable requests
// RL9: lock bit live, read-only; unlocked divides by 4
// RL10: locked divides by post-divider plus one
// RL11: qualified status change sets bit 1
// RL12: osc change flag with enable requests
// RL13: qualified bit read-only, cleared by full stop
// RL14: qualified only while filter continuously qualifies
// RL15: lock loss drops qualified, pseudo stop excepted
// RL16: enable register bits 7,4,1 always accessible
// RL17: multiplier or divider write clears both status
// RL18: request stands while flag and enable set
`include "cuf_defs.vh"

module cuf_flag_regs #(
	parameter integer QUAL_CYC = `CUF_QUAL_CYC
) (
	// clock and resets
	input  wire                   CLK,
	input  wire                   RESET_N,
	input  wire                   POR_N,
	// apb slave
	input  wire                   PSEL,
	input  wire                   PENABLE,
	input  wire                   PWRITE,
	input  wire [`CUF_ADDR_W-1:0] PADDR,
	input  wire [31:0]            PWDATA,
	output reg  [31:0]            PRDATA,
	output wire                   PREADY,
	output wire                   PSLVERR,
	// event sources
	input  wire                   TICK_TIMEOUT,
	input  wire                   LVR_EVENT,
	input  wire                   BAD_ADDR_EVENT,
	// pll and oscillator
	input  wire                   PLL_LOCK_IN,
	input  wire                   OSC_FILTER_GOOD,
	input  wire                   SYNTH_WRITE,
	input  wire                   REFDIV_WRITE,
	// power modes
	input  wire                   FULL_STOP_ENTER,
	input  wire                   PSEUDO_STOP,
	// requests and clock control
	output wire                   IRQ_TICK,
	output wire                   IRQ_PLL,
	output wire                   IRQ_OSC,
	output wire                   OSC_CLK_EN,
	output reg  [`CUF_DIV_W-1:0]  PLL_DIVISOR
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	localparam [`CUF_ADDR_W-1:0] A_FLAGS =
		{`CUF_IDX_FLAGS, 2'b00};
	localparam [`CUF_ADDR_W-1:0] A_IRQEN =
		{`CUF_IDX_IRQEN, 2'b00};
	localparam [`CUF_ADDR_W-1:0] A_PDIV =
		{`CUF_IDX_PDIV, 2'b00};

	// only the low byte of each word is implemented; the upper
	// bits read zero and writes to them are dropped
	wire sys_rst_n;
	wire hit_flags;
	wire hit_irqen;
	wire hit_pdiv;
	wire mapped;
	wire wr_en;
	wire rd_setup;

	// power-on reset also resets everything a system reset does
	assign sys_rst_n = RESET_N & POR_N;

	assign hit_flags = (PADDR == A_FLAGS);
	assign hit_irqen = (PADDR == A_IRQEN);
	assign hit_pdiv  = (PADDR == A_PDIV);
	assign mapped    = hit_flags | hit_irqen | hit_pdiv;

	// zero wait states: every access phase completes at once
	assign PREADY   = 1'b1;
	assign PSLVERR  = PSEL & PENABLE & ~mapped;
	assign wr_en    = PSEL & PENABLE & PWRITE & mapped;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

	wire       wr_flags;
	wire       wr_irqen;
	wire       wr_pdiv;
	wire [7:0] w1c;

	assign wr_flags = wr_en & hit_flags;
	assign wr_irqen = wr_en & hit_irqen;
	assign wr_pdiv  = wr_en & hit_pdiv;
	assign w1c      = wr_flags ? PWDATA[7:0] : 8'h00; // RL2

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// enable bits other than 7, 4 and 1 are never stored
	reg [7:0]             irqen_q;
	reg [`CUF_PDIV_W-1:0] pdiv_q;

	always @(posedge CLK) begin
		if (!sys_rst_n) begin
			irqen_q <= `CUF_IRQEN_RST;
			pdiv_q  <= `CUF_PDIV_RST;
		end else begin
			if (wr_irqen) begin
				irqen_q <= PWDATA[7:0] & `CUF_IRQEN_MASK; // RL16
			end
			if (wr_pdiv) begin
				pdiv_q <= PWDATA[`CUF_PDIV_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// pll settled status
	// ----------------------------------------------------------------
	// a reprogrammed pll is not trusted until the lock detector
	// has dropped once; otherwise a stale lock would leak through
	wire cfg_wr;
	reg  relock_wait_q;
	reg  lock_q;
	wire lock_d;
	wire lock_lost;

	assign cfg_wr = SYNTH_WRITE | REFDIV_WRITE;

	always @(posedge CLK) begin
		if (!sys_rst_n) begin
			relock_wait_q <= 1'b0;
		end else if (cfg_wr) begin
			relock_wait_q <= 1'b1; // RL17
		end else if (!PLL_LOCK_IN) begin
			relock_wait_q <= 1'b0;
		end
	end

	assign lock_d = PLL_LOCK_IN & ~relock_wait_q & ~cfg_wr; // RL9 RL17

	always @(posedge CLK) begin
		if (!sys_rst_n) begin
			lock_q <= 1'b0;
		end else begin
			lock_q <= lock_d; // RL9
		end
	end

	assign lock_lost = lock_q & ~lock_d;

	// ----------------------------------------------------------------
	// pll output divisor
	// ----------------------------------------------------------------
	// switches on the same edge as the lock bit; the sixth bit
	// takes the carry when the post-divider holds its maximum
	localparam [`CUF_DIV_W-1:0] DIV_ONE =
		{{(`CUF_DIV_W-1){1'b0}}, 1'b1};

	always @(posedge CLK) begin
		if (!sys_rst_n) begin
			PLL_DIVISOR <= `CUF_UNLOCK_DIV;
		end else if (lock_d) begin
			PLL_DIVISOR <= {1'b0, pdiv_q} + DIV_ONE; // RL10
		end else begin
			PLL_DIVISOR <= `CUF_UNLOCK_DIV; // RL9
		end
	end

	// ----------------------------------------------------------------
	// oscillator qualified status
	// ----------------------------------------------------------------
	// pseudo stop loses lock on purpose and keeps the oscillator
	wire osc_drop;
	wire osc_ok;
	reg  osc_seen_q;

	assign osc_drop = FULL_STOP_ENTER // RL13
		| cfg_wr // RL17
		| (lock_lost & ~PSEUDO_STOP); // RL15

	cuf_osc_qual #(
		.QUAL_CYC(QUAL_CYC)
	) u_qual (
		.CLK    (CLK),
		.RESET_N(sys_rst_n),
		.GOOD   (OSC_FILTER_GOOD), // RL14
		.DROP   (osc_drop),
		.QUAL_Q (osc_ok)
	);

	always @(posedge CLK) begin
		if (!sys_rst_n) begin
			osc_seen_q <= 1'b0;
		end else begin
			osc_seen_q <= osc_ok;
		end
	end

	// network controller oscillator clock is gated while unqualified
	assign OSC_CLK_EN = osc_ok; // RL13

	// ----------------------------------------------------------------
	// status change detection
	// ----------------------------------------------------------------
	// both directions count: a lost lock matters to software as
	// much as a gained one
	wire lock_chg;
	wire osc_chg;

	assign lock_chg = lock_d ^ lock_q; // RL7
	assign osc_chg  = osc_ok ^ osc_seen_q; // RL11

	// ----------------------------------------------------------------
	// event flags: tick, lock change, oscillator change
	// ----------------------------------------------------------------
	localparam integer NEV = 3;

	wire [NEV-1:0] ev_set;
	wire [NEV-1:0] ev_clr;
	wire [NEV-1:0] ev_flag;
	wire [NEV-1:0] ev_en;

	assign ev_set[0] = TICK_TIMEOUT; // RL1
	assign ev_set[1] = lock_chg; // RL7
	assign ev_set[2] = osc_chg; // RL11
	assign ev_clr[0] = w1c[`CUF_B_TICK];
	assign ev_clr[1] = w1c[`CUF_B_PLLCHG];
	assign ev_clr[2] = w1c[`CUF_B_OSCCHG];
	assign ev_en[0]  = irqen_q[`CUF_B_TICK];
	assign ev_en[1]  = irqen_q[`CUF_B_PLLCHG];
	assign ev_en[2]  = irqen_q[`CUF_B_OSCCHG];

	genvar gi;
	generate
		for (gi = 0; gi < NEV; gi = gi + 1) begin : g_ev
			cuf_w1c_flag u_flag (
				.CLK    (CLK),
				.RESET_N(sys_rst_n),
				.SET    (ev_set[gi]),
				.CLR    (ev_clr[gi]), // RL2
				.FLAG_Q (ev_flag[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// interrupt requests
	// ----------------------------------------------------------------
	// level requests: they fall only when software clears the flag
	// or drops the enable, or when a system or power-on reset clears both
	assign IRQ_TICK = ev_flag[0] & ev_en[0]; // RL3 RL18
	assign IRQ_PLL  = ev_flag[1] & ev_en[1]; // RL8 RL18
	assign IRQ_OSC  = ev_flag[2] & ev_en[2]; // RL12 RL18

	// ----------------------------------------------------------------
	// reset cause flags
	// ----------------------------------------------------------------
	// these see only the power-on reset, so a system reset keeps
	// the cause visible for software after the restart
	reg  por_flag_q;
	reg  lvr_flag_q;
	reg  bad_flag_q;
	wire por_clr;
	wire lvr_clr;
	wire bad_clr;

	// a bus write while the system reset is held must not erase
	// a cause that software has yet to read
	assign por_clr = RESET_N & w1c[`CUF_B_POR]; // RL2
	assign lvr_clr = RESET_N & w1c[`CUF_B_LVR]; // RL2
	assign bad_clr = RESET_N & w1c[`CUF_B_BADADR]; // RL2

	always @(posedge CLK) begin
		if (!POR_N) begin
			por_flag_q <= `CUF_POR_FLAG_RST; // RL4
		end else if (por_clr) begin
			por_flag_q <= 1'b0;
		end
	end

	// an event wins over a clear in the same cycle
	always @(posedge CLK) begin
		if (!POR_N) begin
			lvr_flag_q <= `CUF_LVR_FLAG_RST; // RL5
		end else if (LVR_EVENT) begin
			lvr_flag_q <= 1'b1; // RL5
		end else if (lvr_clr) begin
			lvr_flag_q <= 1'b0;
		end
	end

	always @(posedge CLK) begin
		if (!POR_N) begin
			bad_flag_q <= `CUF_BAD_FLAG_RST; // RL6
		end else if (BAD_ADDR_EVENT) begin
			bad_flag_q <= 1'b1; // RL6
		end else if (bad_clr) begin
			bad_flag_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	reg [7:0] flags_rd;

	always @* begin
		flags_rd                 = 8'h00;
		flags_rd[`CUF_B_TICK]    = ev_flag[0];
		flags_rd[`CUF_B_POR]     = por_flag_q;
		flags_rd[`CUF_B_LVR]     = lvr_flag_q;
		flags_rd[`CUF_B_PLLCHG]  = ev_flag[1];
		flags_rd[`CUF_B_PLLOK]   = lock_q;
		flags_rd[`CUF_B_BADADR]  = bad_flag_q;
		flags_rd[`CUF_B_OSCCHG]  = ev_flag[2];
		flags_rd[`CUF_B_OSCOK]   = osc_ok;
	end

	// data captured in setup phase, valid through the access phase
	// unmapped words read zero while the error line is raised
	always @(posedge CLK) begin
		if (!sys_rst_n) begin
			PRDATA <= 32'h0000_0000;
		end else if (rd_setup) begin
			if (hit_flags) begin
				PRDATA <= {24'h00_0000, flags_rd};
			end else if (hit_irqen) begin
				PRDATA <= {24'h00_0000, irqen_q}; // RL16
			end else if (hit_pdiv) begin
				PRDATA <= {{(32-`CUF_PDIV_W){1'b0}}, pdiv_q};
			end else begin
				PRDATA <= 32'h0000_0000;
			end
		end
	end

endmodule // cuf_flag_regs

// [testbench/cuf_flag_regs_assertions.sv]
// checker for the clock unit flag and enable registers
`include "cuf_defs.vh"
module cuf_flag_regs_chk (
	// clock and resets
	input wire                    CLK,
	input wire                    RESET_N,
	input wire                    POR_N,
	// apb
	input wire                    PSEL,
	input wire                    PENABLE,
	input wire                    PWRITE,
	input wire [`CUF_ADDR_W-1:0]  PADDR,
	input wire [31:0]             PWDATA,
	input wire                    PREADY,
	input wire                    PSLVERR,
	// events and status
	input wire                    TICK_TIMEOUT,
	input wire                    PLL_LOCK_IN,
	input wire                    OSC_FILTER_GOOD,
	input wire                    SYNTH_WRITE,
	input wire                    FULL_STOP_ENTER,
	input wire                    PSEUDO_STOP,
	input wire                    IRQ_TICK,
	input wire                    IRQ_PLL,
	input wire                    IRQ_OSC,
	input wire                    OSC_CLK_EN,
	input wire [`CUF_DIV_W-1:0]   PLL_DIVISOR
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// shadow of the enable register
	// ----------------------------------------
	logic [7:0] en_q;
	wire        wr = PSEL && PENABLE && PWRITE && PREADY;
	always @(posedge CLK)
		if (!RESET_N || !POR_N)
			en_q <= 8'h00;
		else if (wr && PADDR == 10'h0E0)
			en_q <= PWDATA[7:0] & 8'h92;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N || !POR_N);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_tick;
		TICK_TIMEOUT |=> IRQ_TICK == en_q[7];
	endproperty
	a_tick: assert property (p_tick) else $error("tick request");
	property p_irq_and;
		(!IRQ_TICK || en_q[7]) && (!IRQ_PLL || en_q[4]) && (!IRQ_OSC || en_q[1]);
	endproperty
	a_irq_and: assert property (p_irq_and) else $error("request gate");
	property p_sticky;
		IRQ_PLL && !wr |=> IRQ_PLL;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_unlock;
		!$past(PLL_LOCK_IN) |-> PLL_DIVISOR == 6'h04;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlocked div");
	property p_cfg;
		SYNTH_WRITE |=> PLL_DIVISOR == 6'h04 && !OSC_CLK_EN;
	endproperty
	a_cfg: assert property (p_cfg) else $error("cfg write");
	property p_fstop;
		FULL_STOP_ENTER |=> !OSC_CLK_EN;
	endproperty
	a_fstop: assert property (p_fstop) else $error("full stop");
	property p_filter;
		!OSC_FILTER_GOOD |=> !OSC_CLK_EN;
	endproperty
	a_filter: assert property (p_filter) else $error("filter low");
	property p_osc_chg;
		$changed(OSC_CLK_EN) ##1 en_q[1] |-> IRQ_OSC;
	endproperty
	a_osc_chg: assert property (p_osc_chg) else $error("osc change");
	property p_lockloss;
		$fell(PLL_LOCK_IN) && PLL_DIVISOR != 6'h04 && !PSEUDO_STOP
			|=> !OSC_CLK_EN;
	endproperty
	a_lockloss: assert property (p_lockloss) else $error("lock loss");
	property p_slverr;
		PSEL && PENABLE |-> PSLVERR ==
			!(PADDR inside {10'h0DC, 10'h0E0, 10'h100});
	endproperty
	a_slverr: assert property (p_slverr) else $error("bad decode");
	c_tick: cover property (TICK_TIMEOUT && en_q[7]);
	c_cfg: cover property (SYNTH_WRITE);
	c_pseudo: cover property ($fell(PLL_LOCK_IN) && PSEUDO_STOP);
endmodule // cuf_flag_regs_chk
bind cuf_flag_regs cuf_flag_regs_chk u_chk (.CLK(CLK), .RESET_N(RESET_N),
	.POR_N(POR_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TICK_TIMEOUT(TICK_TIMEOUT), .PLL_LOCK_IN(PLL_LOCK_IN),
	.OSC_FILTER_GOOD(OSC_FILTER_GOOD), .SYNTH_WRITE(SYNTH_WRITE),
	.FULL_STOP_ENTER(FULL_STOP_ENTER), .PSEUDO_STOP(PSEUDO_STOP),
	.IRQ_TICK(IRQ_TICK), .IRQ_PLL(IRQ_PLL), .IRQ_OSC(IRQ_OSC),
	.OSC_CLK_EN(OSC_CLK_EN), .PLL_DIVISOR(PLL_DIVISOR));

// [testbench/cuf_cpu_model.sv]
// processor interrupt side: remembers every request it saw
module cuf_cpu_model (
	// clock
	input wire         CLK,
	// requests
	input wire  [2:0]  IRQ,
	// log
	output logic [2:0] SEEN
);
	timeunit 1ns;
	timeprecision 1ns;
	// level requests: sampled only at clock edges
	initial begin
		SEEN = 3'b000;
		forever @(posedge CLK) SEEN <= SEEN | IRQ;
	end
endmodule // cuf_cpu_model

// [testbench/cuf_flag_regs_tb.sv]
// self-checking bench for the clock unit flag registers
module cuf_flag_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [9:0] FLG = 10'h0DC, IEN = 10'h0E0;
	localparam logic [9:0] PDV = 10'h100, NOP = 10'h0E4;
	logic clk, reset_n, por_n, psel, penable, pwrite, pready, serr;
	logic tick, lvr, bad, lock, filt, syn, refw, fst, pst, pslverr;
	logic irq_tick, irq_pll, irq_osc, osc_en;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [5:0]  div;
	logic [2:0]  seen;
	int          bad_count, checks_done, cyc_n;
	cuf_flag_regs #(.QUAL_CYC(3)) DUT (.CLK(clk), .RESET_N(reset_n),
		.POR_N(por_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TICK_TIMEOUT(tick), .LVR_EVENT(lvr),
		.BAD_ADDR_EVENT(bad), .PLL_LOCK_IN(lock), .OSC_FILTER_GOOD(filt),
		.SYNTH_WRITE(syn), .REFDIV_WRITE(refw), .FULL_STOP_ENTER(fst),
		.PSEUDO_STOP(pst), .IRQ_TICK(irq_tick), .IRQ_PLL(irq_pll),
		.IRQ_OSC(irq_osc), .OSC_CLK_EN(osc_en), .PLL_DIVISOR(div));
	cuf_cpu_model u_cpu (.CLK(clk), .IRQ({irq_tick, irq_pll, irq_osc}),
		.SEEN(seen));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		apb(0, a, 0);
		chk(rdat, e);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		apb(1, a, {24'h00_0000, d});
	endtask
	task automatic rst(input logic p);
		@(posedge clk);
		if (p)
			por_n <= 0;
		else
			reset_n <= 0;
		cyc(2);
		por_n <= 1;
		reset_n <= 1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(FLG, 8'h60);
		rd(IEN, 8'h00);
		chk(div, 6'h04);
		wr(FLG, 8'h00);
		rd(FLG, 8'h60);
		@(posedge clk) bad <= 1;
		@(posedge clk) bad <= 0;
		wr(FLG, 8'h40);
		rd(FLG, 8'h24);
		rst(0);
		rd(FLG, 8'h24);
		rst(1);
		rd(FLG, 8'h60);
		wr(FLG, 8'hFF);
		@(posedge clk) lvr <= 1;
		@(posedge clk) lvr <= 0;
		rd(FLG, 8'h20);
		wr(FLG, 8'h20);
	endtask
	task automatic t_tick;
		wr(IEN, 8'hFF);
		rd(IEN, 8'h92);
		@(posedge clk) tick <= 1;
		@(posedge clk) tick <= 0;
		rd(FLG, 8'h80);
		chk(irq_tick, 1);
		wr(FLG, 8'h7F);
		rd(FLG, 8'h80);
		wr(IEN, 8'h00);
		rd(IEN, 8'h00);
		chk(irq_tick, 0);
		wr(IEN, 8'h92);
		wr(FLG, 8'h80);
		rd(FLG, 8'h00);
		chk(irq_tick, 0);
		apb(0, NOP, 0);
		chk(serr, 1);
		chk(rdat, 0);
	endtask
	task automatic t_pll;
		wr(PDV, 8'h05);
		rd(PDV, 8'h05);
		@(posedge clk) lock <= 1;
		cyc(2);
		rd(FLG, 8'h18);
		chk(div, 6'h06);
		chk(irq_pll, 1);
		wr(FLG, 8'h10);
		@(posedge clk) filt <= 1;
		cyc(8);
		rd(FLG, 8'h0B);
		chk(irq_osc, 1);
		chk(osc_en, 1);
		wr(FLG, 8'h0B);
		rd(FLG, 8'h09);
		@(posedge clk) syn <= 1;
		@(posedge clk) syn <= 0;
		rd(FLG, 8'h12);
		chk(div, 6'h04);
		wr(FLG, 8'h12);
		@(posedge clk) lock <= 0;
		cyc(2);
		lock <= 1;
		cyc(10);
		rd(FLG, 8'h19);
		wr(FLG, 8'h12);
		@(posedge clk) pst <= 1;
		lock <= 0;
		cyc(4);
		rd(FLG, 8'h11);
		@(posedge clk) pst <= 0;
		lock <= 1;
		cyc(3);
		lock <= 0;
		cyc(3);
		chk(osc_en, 0);
		lock <= 1;
		cyc(3);
		chk(div, 6'h06);
		refw <= 1;
		@(posedge clk) refw <= 0;
		cyc(1);
		chk(div, 6'h04);
		cyc(6);
		chk(osc_en, 1);
		fst <= 1;
		@(posedge clk) fst <= 0;
		cyc(1);
		chk(osc_en, 0);
	endtask
	// ----------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			bad_count++;
			wrap_up;
		end
	end
	initial begin
		{psel, penable, pwrite, tick, lvr, bad, lock} = '0;
		{filt, syn, refw, fst, pst} = '0;
		paddr = '0;
		pwdata = '0;
		reset_n = 0;
		por_n = 0;
		cyc(2);
		reset_n <= 1;
		por_n <= 1;
		t_reset;
		t_tick;
		t_pll;
		chk(seen, 3'b111);
		wrap_up;
	end
endmodule // cuf_flag_regs_tb
